/* hw/fpexd_cfg.svh */
// constants for the floating-point exception detect block
`ifndef FPEXD_CFG_SVH
`define FPEXD_CFG_SVH
`define FPEXD_ADDR_CTRL 12'h000
`define FPEXD_ADDR_STAT 12'h004
`define FPEXD_ADDR_TAGS 12'h008
`define FPEXD_ADDR_OP 12'h00C
`define FPEXD_ADDR_LAST 12'h010
`define FPEXD_ADDR_DEST 12'h014
`define FPEXD_ADDR_RESTORE 12'h018
`define FPEXD_BIT_IE 0
`define FPEXD_BIT_SF 6
`define FPEXD_BIT_ES 7
`define FPEXD_BIT_C1 9
`define FPEXD_CTRL_RST 16'h037F
`define FPEXD_TAG_EMPTY 2'h3
`define FPEXD_TAG_VALID 2'h0
`define FPEXD_IND_FP 32'hFFC00000
`define FPEXD_IND_INT 32'h80000000
`define FPEXD_IND_BCD 32'hFFFF0000
`endif

/* hw/fpexd_pkg.sv */
// types for the floating-point exception detect block
package fpexd_pkg;
	typedef enum logic [3:0] {
		FPEXD_OP_NOP,
		FPEXD_OP_LOAD_FP,
		FPEXD_OP_LOAD_EXT,
		FPEXD_OP_LOAD_INT,
		FPEXD_OP_LOAD_BCD,
		FPEXD_OP_STORE_FP,
		FPEXD_OP_STORE_EXT,
		FPEXD_OP_STORE_INT,
		FPEXD_OP_STORE_BCD,
		FPEXD_OP_TRUNC_INT_STORE,
		FPEXD_OP_ARITH,
		FPEXD_OP_NONARITH_SRC,
		FPEXD_OP_LOAD_CW,
		FPEXD_OP_RESTORE,
		FPEXD_OP_RESTORE_EXT
	} fpexd_op_type;
	typedef struct packed {
		logic valid;
		fpexd_op_type op;
		logic [5:0] arith_exc;
		logic [15:0] data;
	} fpexd_instr_type;
	typedef struct packed {
		logic valid;
		logic fault;
		logic handler;
		logic write_dest;
		logic [31:0] dest_value;
	} fpexd_result_type;
endpackage

/* hw/fpexd_top.sv */
// exception detect and flag logic of a stack-based floating-point unit
//
// Design decisions made here: the APB slave port and the placing of the registers.
`include "fpexd_cfg.svh"
module fpexd_top #(
	parameter int NUM_REGS = 8,
	parameter int NUM_EXC = 6
) (
	input wire logic clk,
	input wire logic rst,
	input wire fpexd_pkg::fpexd_instr_type instr,
	output fpexd_pkg::fpexd_result_type result,
	output logic [2:0] stack_top,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	import fpexd_pkg::*;

	logic [NUM_EXC-1:0] mask_ff;
	logic [15:0] ctrl_rest_ff;
	logic [NUM_EXC-1:0] flag_ff;
	logic stack_fault_flag_ff;
	logic cond_code_one_ff;
	logic error_summary_flag_ff;
	logic [2:0] top_ff;
	logic [1:0] tags_ff [NUM_REGS];
	logic [31:0] last_ff;
	fpexd_result_type result_ff;
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;

	logic is_load;
	logic is_store;
	logic uses_src;
	logic is_arith;
	logic [2:0] push_idx;
	logic overflow;
	logic underflow;
	logic stack_fault_exc;
	logic bad_operand_exc;
	logic invalid_op_mask;
	logic [NUM_EXC-1:0] raised;
	logic [NUM_EXC-1:0] nxt_flag;
	logic [31:0] indef;
	logic [15:0] tag_word;
	logic [15:0] status_word;
	logic [15:0] ctrl_word;
	logic apb_wr;
	logic apb_rd;
	logic sw_ctrl_wr;
	logic sw_stat_wr;
	logic sw_tag_wr;

	// decode the instruction class
	always_comb begin
		is_load = 1'b0;
		is_store = 1'b0;
		uses_src = 1'b0;
		is_arith = 1'b0;
		unique case (instr.op)
			FPEXD_OP_LOAD_FP, FPEXD_OP_LOAD_INT, FPEXD_OP_LOAD_BCD: begin
				is_load = 1'b1;
				is_arith = 1'b1;
			end
			FPEXD_OP_LOAD_EXT: begin
				is_load = 1'b1;
			end
			FPEXD_OP_STORE_FP, FPEXD_OP_STORE_INT, FPEXD_OP_STORE_BCD: begin
				is_store = 1'b1;
				uses_src = 1'b1;
				is_arith = 1'b1;
			end
			FPEXD_OP_TRUNC_INT_STORE: begin
				is_store = 1'b1;
				uses_src = 1'b1;
				is_arith = 1'b1;
			end
			FPEXD_OP_STORE_EXT, FPEXD_OP_NONARITH_SRC: begin
				uses_src = 1'b1;
				is_store = (instr.op == FPEXD_OP_STORE_EXT);
			end
			FPEXD_OP_ARITH: begin
				uses_src = 1'b1;
				is_arith = 1'b1;
			end
			default: begin
			end
		endcase
	end

	// stack fault detection from the tag of the touched register
	always_comb begin
		push_idx = top_ff - 3'h1; // wraps modulo eight
		overflow = instr.valid && is_load && (tags_ff[push_idx] != `FPEXD_TAG_EMPTY);
		underflow = instr.valid && uses_src && (tags_ff[top_ff] == `FPEXD_TAG_EMPTY);
		stack_fault_exc = overflow || underflow;
		bad_operand_exc = instr.valid && is_arith && !stack_fault_exc && instr.arith_exc[0];
		invalid_op_mask = mask_ff[`FPEXD_BIT_IE];
	end

	// classes raised by this instruction
	always_comb begin
		raised = '0;
		if (instr.valid && !stack_fault_exc && is_arith) begin
			raised = instr.arith_exc;
		end
		raised[`FPEXD_BIT_IE] = stack_fault_exc || bad_operand_exc;
	end

	// indefinite value matching the destination format
	always_comb begin
		unique case (instr.op)
			FPEXD_OP_STORE_INT, FPEXD_OP_TRUNC_INT_STORE: indef = `FPEXD_IND_INT;
			FPEXD_OP_STORE_BCD: indef = `FPEXD_IND_BCD;
			default: indef = `FPEXD_IND_FP;
		endcase
	end

	// apb decode
	always_comb begin
		// writes land on the edge where the master samples pready high
		apb_wr = psel && penable && pwrite && pready_ff;
		apb_rd = psel && penable && !pwrite && !pready_ff;
		sw_ctrl_wr = apb_wr && (paddr == `FPEXD_ADDR_CTRL);
		sw_stat_wr = apb_wr && (paddr == `FPEXD_ADDR_STAT);
		sw_tag_wr = apb_wr && (paddr == `FPEXD_ADDR_TAGS);
	end

	// sticky flags; a raise in the clearing cycle wins
	always_comb begin
		nxt_flag = flag_ff;
		if (sw_stat_wr) begin
			nxt_flag = pwdata[NUM_EXC-1:0];
		end
		nxt_flag = nxt_flag | raised;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			flag_ff <= '0;
		end else begin
			flag_ff <= nxt_flag;
		end
	end

	// stack fault flag and condition code one
	always_ff @(posedge clk) begin
		if (rst) begin
			stack_fault_flag_ff <= 1'b0;
			cond_code_one_ff <= 1'b0;
		end else if (stack_fault_exc) begin
			stack_fault_flag_ff <= 1'b1;
			cond_code_one_ff <= overflow;
		end else if (sw_stat_wr) begin
			stack_fault_flag_ff <= pwdata[`FPEXD_BIT_SF];
			cond_code_one_ff <= pwdata[`FPEXD_BIT_C1];
		end
	end

	// summary flag follows flags and masks
	always_ff @(posedge clk) begin
		if (rst) begin
			error_summary_flag_ff <= 1'b0;
		end else begin
			error_summary_flag_ff <= |(nxt_flag & ~(sw_ctrl_wr ? pwdata[NUM_EXC-1:0] : mask_ff));
		end
	end

	// control word, loaded by control-word and restore ops or by software
	always_ff @(posedge clk) begin
		if (rst) begin
			mask_ff <= NUM_EXC'(`FPEXD_CTRL_RST);
			ctrl_rest_ff <= `FPEXD_CTRL_RST;
		end else if (sw_ctrl_wr) begin
			mask_ff <= pwdata[NUM_EXC-1:0];
			ctrl_rest_ff <= pwdata[15:0];
		end else if (instr.valid && (instr.op == FPEXD_OP_LOAD_CW || instr.op == FPEXD_OP_RESTORE
				|| instr.op == FPEXD_OP_RESTORE_EXT)) begin
			mask_ff <= instr.data[NUM_EXC-1:0];
			ctrl_rest_ff <= instr.data;
		end
	end

	// stack pointer and tags; frozen on an unmasked fault
	always_ff @(posedge clk) begin
		if (rst) begin
			top_ff <= '0;
		end else if (instr.valid && !(stack_fault_exc && !invalid_op_mask)) begin
			if (is_load) begin
				top_ff <= push_idx;
			end else if (is_store) begin
				top_ff <= top_ff + 3'h1;
			end
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_REGS; gi++) begin : g_tag
			always_ff @(posedge clk) begin
				if (rst) begin
					tags_ff[gi] <= `FPEXD_TAG_EMPTY;
				end else if (sw_tag_wr) begin
					tags_ff[gi] <= pwdata[2*gi +: 2];
				end else if (instr.valid && !(stack_fault_exc && !invalid_op_mask)) begin
					if (is_load && (3'(gi) == push_idx)) begin
						tags_ff[gi] <= `FPEXD_TAG_VALID; // masked overflow holds indefinite
					end else if (is_store && (3'(gi) == top_ff)) begin
						tags_ff[gi] <= `FPEXD_TAG_EMPTY;
					end
				end
			end
			assign tag_word[2*gi +: 2] = tags_ff[gi];
		end
	endgenerate

	// outcome of each instruction
	always_ff @(posedge clk) begin
		if (rst) begin
			result_ff <= '0;
			last_ff <= '0;
		end else begin
			result_ff.valid <= instr.valid;
			result_ff.fault <= stack_fault_exc;
			result_ff.handler <= instr.valid && (|(raised & ~mask_ff));
			result_ff.write_dest <= stack_fault_exc && invalid_op_mask;
			result_ff.dest_value <= (stack_fault_exc || bad_operand_exc) ? indef : 32'h0;
			if (instr.valid) begin
				last_ff <= {26'h0, stack_fault_exc && invalid_op_mask, stack_fault_exc,
					bad_operand_exc, overflow, underflow, is_arith};
			end
		end
	end

	// readable words for the apb read port
	always_comb begin
		status_word = '0;
		status_word[NUM_EXC-1:0] = flag_ff;
		status_word[`FPEXD_BIT_SF] = stack_fault_flag_ff;
		status_word[`FPEXD_BIT_ES] = error_summary_flag_ff;
		status_word[`FPEXD_BIT_C1] = cond_code_one_ff;
		status_word[13:11] = top_ff;
		ctrl_word = {ctrl_rest_ff[15:NUM_EXC], mask_ff};
	end

	// apb slave, one wait state
	always_ff @(posedge clk) begin
		if (rst) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= '0;
		end else begin
			pready_ff <= psel && penable && !pready_ff;
			pslverr_ff <= psel && penable && !pready_ff && (paddr > `FPEXD_ADDR_RESTORE);
			if (apb_rd) begin
				unique case (paddr)
					`FPEXD_ADDR_CTRL: prdata_ff <= {16'h0, ctrl_word};
					`FPEXD_ADDR_STAT: prdata_ff <= {16'h0, status_word};
					`FPEXD_ADDR_TAGS: prdata_ff <= {16'h0, tag_word};
					`FPEXD_ADDR_LAST: prdata_ff <= last_ff;
					`FPEXD_ADDR_DEST: prdata_ff <= result_ff.dest_value;
					default: prdata_ff <= '0;
				endcase
			end
		end
	end

	assign result = result_ff;
	assign stack_top = top_ff;
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
endmodule

/* dv/fpexd_sva.sv */
// port assertions for the exception detect block
`include "fpexd_cfg.svh"
module fpexd_sva (
	input wire logic clk,
	input wire logic rst,
	input wire fpexd_pkg::fpexd_instr_type instr,
	input wire fpexd_pkg::fpexd_result_type result,
	input wire logic [2:0] stack_top
);
	import fpexd_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// every instruction answers one cycle later
	a_result_latency: assert property (instr.valid |=> result.valid)
		else $error("result missing after instruction");
	// control loads never fault
	a_fault_cause: assert property (result.fault |-> $past(instr.valid)
		&& $past(instr.op) != FPEXD_OP_LOAD_CW) else $error("fault without cause");
	// destination written only on a masked fault
	a_dest_masked: assert property (result.write_dest |-> result.fault
		&& !result.handler) else $error("destination write outside masked fault");
	// indefinite value follows the store kind
	a_fp_indef: assert property (result.write_dest && $past(instr.op) ==
		FPEXD_OP_STORE_FP |-> result.dest_value == `FPEXD_IND_FP) else $error("bad fp value");
	a_int_indef: assert property (result.write_dest && $past(instr.op) inside
		{FPEXD_OP_STORE_INT, FPEXD_OP_TRUNC_INT_STORE} |-> result.dest_value == `FPEXD_IND_INT)
		else $error("bad integer value");
	a_bcd_indef: assert property (result.write_dest && $past(instr.op) ==
		FPEXD_OP_STORE_BCD |-> result.dest_value == `FPEXD_IND_BCD) else $error("bad bcd value");
	// unmasked fault keeps the stack pointer
	a_top_frozen: assert property (result.handler && result.fault |-> $stable(stack_top))
		else $error("stack top moved on handled fault");
	// non-arithmetic ops without a fault stay quiet
	a_nonarith_quiet: assert property (instr.valid && instr.op == FPEXD_OP_NONARITH_SRC
		##1 !result.fault |-> !result.handler) else $error("non-arithmetic op raised exception");
endmodule
bind fpexd_top fpexd_sva u_sva (.clk(clk), .rst(rst), .instr(instr), .result(result),
	.stack_top(stack_top));

/* dv/fpexd_core_model.sv */
// core model issuing instructions to the exception detect block
module fpexd_core_model (
	input wire logic clk,
	output fpexd_pkg::fpexd_instr_type instr,
	input wire fpexd_pkg::fpexd_result_type result
);
	timeunit 1ns;
	timeprecision 1ns;
	import fpexd_pkg::*;
	fpexd_result_type res;
	initial instr = '0;
	// one instruction for one cycle, result taken one cycle later
	task automatic issue(input fpexd_op_type op, input logic [5:0] exc, input logic [15:0] d);
		@(posedge clk);
		instr <= '{1'b1, op, exc, d};
		@(posedge clk);
		instr <= '0;
		#1;
		res = result;
	endtask
endmodule

/* dv/fpu_exception_detect_bench.sv */
// self-checking bench for the exception detect block
`include "fpexd_cfg.svh"
module fpu_exception_detect_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import fpexd_pkg::*;
	typedef struct {fpexd_op_type op; logic [31:0] dest;} fpexd_row_type;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0] stack_top, top0;
	fpexd_instr_type instr;
	fpexd_result_type result;
	int n_mismatch, n_checks, cyc;
	fpexd_row_type rows[4] = '{'{FPEXD_OP_STORE_FP, `FPEXD_IND_FP},
		'{FPEXD_OP_STORE_INT, `FPEXD_IND_INT}, '{FPEXD_OP_STORE_BCD, `FPEXD_IND_BCD},
		'{FPEXD_OP_TRUNC_INT_STORE, `FPEXD_IND_INT}};
	fpexd_top dut (.clk(clk), .rst(rst), .instr(instr), .result(result), .stack_top(stack_top),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	fpexd_core_model core (.clk(clk), .instr(instr), .result(result));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// cycle ceiling against a hang
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 2000) begin
			n_mismatch++;
			close_out();
		end
	end
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		{rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		// reset values
		apb(1'b0, `FPEXD_ADDR_CTRL, 32'h0);
		chk("ctrl", rd[15:0], `FPEXD_CTRL_RST);
		apb(1'b0, `FPEXD_ADDR_TAGS, 32'h0);
		chk("tags", rd[15:0], 16'hFFFF);
		apb(1'b0, `FPEXD_ADDR_STAT, 32'h0);
		chk("stat", rd[15:0], 16'h0000);
		// masked underflow on every store kind except the extended store
		foreach (rows[i]) begin
			core.issue(rows[i].op, 6'h00, 16'h0000);
			chk("fault", core.res.fault, 1'b1);
			chk("dest", core.res.dest_value, rows[i].dest);
		end
		apb(1'b0, `FPEXD_ADDR_STAT, 32'h0);
		chk("stat", rd[9:0], 10'h041);
		// eight pushes fill the stack, the ninth overflows
		for (int i = 0; i < 9; i++) begin
			core.issue(FPEXD_OP_LOAD_FP, 6'h00, 16'h0000);
			chk("ovf", core.res.fault, i == 8);
		end
		apb(1'b0, `FPEXD_ADDR_STAT, 32'h0);
		chk("stat", rd[9:0], 10'h241);
		// unmask invalid: summary rises, fault goes to the handler
		apb(1'b1, `FPEXD_ADDR_CTRL, 32'h0000037E);
		apb(1'b0, `FPEXD_ADDR_CTRL, 32'h0);
		chk("ctrl", rd[15:0], 16'h037E);
		apb(1'b0, `FPEXD_ADDR_STAT, 32'h0);
		chk("es", rd[7], 1'b1);
		top0 = stack_top;
		core.issue(FPEXD_OP_LOAD_FP, 6'h00, 16'h0000);
		chk("handler", core.res.handler, 1'b1);
		chk("wr", core.res.write_dest, 1'b0);
		chk("top", stack_top, top0);
		// clear flags, re-mask through the core
		apb(1'b1, `FPEXD_ADDR_STAT, 32'h0);
		core.issue(FPEXD_OP_LOAD_CW, 6'h00, 16'h037F);
		apb(1'b0, `FPEXD_ADDR_CTRL, 32'h0);
		chk("ctrl", rd[15:0], 16'h037F);
		// bad operand after a stack fault keeps the fault flag
		core.issue(FPEXD_OP_ARITH, 6'h01, 16'h0000);
		apb(1'b0, `FPEXD_ADDR_STAT, 32'h0);
		chk("ie", rd[0], 1'b1);
		core.issue(FPEXD_OP_LOAD_FP, 6'h00, 16'h0000);
		core.issue(FPEXD_OP_ARITH, 6'h01, 16'h0000);
		apb(1'b0, `FPEXD_ADDR_STAT, 32'h0);
		chk("sf", rd[6], 1'b1);
		// non-arithmetic op quiet, truncating store and arithmetic raise
		apb(1'b1, `FPEXD_ADDR_STAT, 32'h0);
		core.issue(FPEXD_OP_NONARITH_SRC, 6'h3F, 16'h0000);
		core.issue(FPEXD_OP_TRUNC_INT_STORE, 6'h20, 16'h0000);
		apb(1'b0, `FPEXD_ADDR_STAT, 32'h0);
		chk("flags", rd[5:0], 6'h20);
		core.issue(FPEXD_OP_ARITH, 6'h1E, 16'h0000);
		apb(1'b0, `FPEXD_ADDR_STAT, 32'h0);
		chk("flags", rd[5:0], 6'h3E);
		// unmapped address refused
		apb(1'b0, 12'h01C, 32'h0);
		chk("slverr", err, 1'b1);
		close_out();
	end
endmodule
